/* File: src/adcss_core.sv */
`timescale 1ns/10ps
// Startup rules from the document, for host, core and receiver
// R1: host straps synth enable and reference select; single-ended needs synth
// R2: host keeps power-down pin low while clock outputs are needed
// R3: host applies stable clock on chosen input before reset
// R4: host soft-resets, then polls init complete until it reads 1
// R5: host sets synth reset, bias 0x4A, dividers, then trim mode
// R6: clearing synth reset starts oscillator trim cal and enables synth
// R7: link enable 0 halts link machine before link settings change
// R8: calibration enable 0 halts calibration machine before settings change
// R9: host programs link mode and K-1; K-1 only used in 8b/10b
// R10: host selects sync from single-ended input or timestamp pair
// R11: host chooses foreground or background and offset options first
// R12: host checks trim cal done and locked before enabling calibration
// R13: host enables calibration, then over-range, then link, in order
// R14: foreground cal starts on soft trigger or pin rising edge
// R15: on calibration end both status pin and done bit go high
// R16: 8b/10b modes obey sync request; 64b/66b modes ignore it
// R17: data valid needs receiver lock plus calibration status
// R18: receiver core clock must be integer multiple of reference
// R19: receiver may need gearbox and timing-preserving crossing
// R20: host bounds every status poll with a timeout
module adcss_core (
   input wire logic sys_clk, // system clock, 200 MHz
   input wire logic reset_n, // async reset, active low
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size
   input wire logic hsel, // ahb slave select
   input wire logic hready, // ahb bus ready
   input wire logic [31:0] hwdata, // ahb write data
   output logic [31:0] hrdata, // ahb read data
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   input wire logic synth_enable_strap, // use internal sampling synth
   input wire logic ref_input_select_strap, // single-ended reference
   input wire logic single_ended_sync_input, // sync request, low active
   input wire logic timestamp_diff_input, // sync request via timestamp
   input wire logic calibration_trigger_pin, // foreground cal trigger
   input wire logic rx_locked, // receiver finished cgs/ilas or header lock
   output logic calibration_status_pin, // calibration finished
   output logic link_running, // link machine running
   output logic link_sync_request, // link held in code-group sync
   output logic data_valid // converter data usable
);
   typedef enum logic [3:0] {
      ST_INIT = 4'b0001,
      ST_IDLE = 4'b0010,
      ST_TRIM = 4'b0100,
      ST_LOCKING = 4'b1000
   } adcss_syn_t;

   typedef struct packed {
      adcss_syn_t syn;
      logic init_done;
      logic synth_reset;
      logic trim_cal_en;
      logic [7:0] bias;
      logic [7:0] trim;
      logic [23:0] div;
      logic trim_done;
      logic locked;
      logic link_en;
      logic [7:0] mode;
      logic [7:0] km1;
      logic sync_sel;
      logic cal_en;
      logic over_range_enable;
      logic soft_trig;
      logic pin_trig_en;
      logic stat_sel;
      logic [7:0] cal_cfg;
      logic [7:0] trig_ctrl;
      logic cal_busy;
      logic foreground_done_bit;
      logic pin_prev;
      logic wr_pend;
      logic rd_pend;
      logic [7:0] addr;
      logic [31:0] rdata;
      logic ready;
      logic stat_pin;
      logic link_run;
      logic sync_req;
      logic valid;
   } adcss_state_t;

   adcss_state_t s_r;
   adcss_state_t s_nxt;
   logic tmr_load;
   logic tmr_hold;
   logic [11:0] tmr_count;
   logic tmr_done;
   logic cal_load;
   logic cal_done;
   logic sync_in;
   logic is_8b10b;
   logic [31:0] rd_mux;

   // ************************************************************
   // timers
   // ************************************************************
   adcss_timer #(.WIDTH(12)) u_syn_tmr (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .load(tmr_load),
      .hold(tmr_hold),
      .count(tmr_count),
      .done(tmr_done)
   );
   adcss_timer #(.WIDTH(12)) u_cal_tmr (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .load(cal_load),
      .hold(!s_r.cal_en),
      .count(12'(adcss_pkg::FG_CAL_CYCLES)),
      .done(cal_done)
   );

   assign is_8b10b = s_r.mode < adcss_pkg::MODES_64B66B_FIRST;
   assign sync_in = s_r.sync_sel ? timestamp_diff_input
                                 : single_ended_sync_input;

   // ************************************************************
   // read mux
   // ************************************************************
   always_comb begin
      rd_mux = '0;
      unique case (s_r.addr)
         adcss_pkg::ADDR_INIT_STAT: rd_mux[0] = s_r.init_done;
         adcss_pkg::ADDR_SYNTH_CTRL: begin
            rd_mux[adcss_pkg::SYNTH_RESET_BIT] = s_r.synth_reset;
            rd_mux[adcss_pkg::TRIM_CAL_EN_BIT] = s_r.trim_cal_en;
            rd_mux[adcss_pkg::BIAS_LSB +: 8] = s_r.bias;
            rd_mux[adcss_pkg::TRIM_LSB +: 8] = s_r.trim;
         end
         adcss_pkg::ADDR_SYNTH_DIV: rd_mux[23:0] = s_r.div;
         adcss_pkg::ADDR_SYNTH_STAT: rd_mux[1:0] = {s_r.locked, s_r.trim_done};
         adcss_pkg::ADDR_LINK_CTRL: rd_mux[adcss_pkg::LINK_EN_BIT] = s_r.link_en;
         adcss_pkg::ADDR_LINK_CFG: begin
            rd_mux[adcss_pkg::MODE_LSB +: 8] = s_r.mode;
            rd_mux[adcss_pkg::KM1_LSB +: 8] = s_r.km1;
            rd_mux[adcss_pkg::SYNC_SEL_BIT] = s_r.sync_sel;
         end
         adcss_pkg::ADDR_CAL_CTRL: begin
            rd_mux[adcss_pkg::CAL_EN_BIT] = s_r.cal_en;
            rd_mux[adcss_pkg::OVER_RANGE_ENABLE_BIT] = s_r.over_range_enable;
            rd_mux[adcss_pkg::SOFT_TRIG_BIT] = s_r.soft_trig;
            rd_mux[adcss_pkg::PIN_TRIG_EN_BIT] = s_r.pin_trig_en;
            rd_mux[adcss_pkg::STAT_SEL_BIT] = s_r.stat_sel;
         end
         adcss_pkg::ADDR_CAL_CFG: rd_mux[7:0] = s_r.cal_cfg;
         adcss_pkg::ADDR_CAL_STAT: rd_mux[1:0] = {s_r.cal_busy, s_r.foreground_done_bit};
         adcss_pkg::ADDR_TRIG_OUT: rd_mux[7:0] = s_r.trig_ctrl;
         default: rd_mux = '0;
      endcase
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic soft_rst;
      logic wr_cal;
      logic trig;
      logic [31:0] w;
      soft_rst = 1'b0;
      wr_cal = 1'b0;
      trig = 1'b0;
      w = hwdata;
      s_nxt = s_r;
      tmr_load = 1'b0;
      tmr_hold = 1'b0;
      tmr_count = 12'(adcss_pkg::INIT_CYCLES);
      cal_load = 1'b0;
      s_nxt.wr_pend = 1'b0;
      s_nxt.rd_pend = 1'b0;
      s_nxt.pin_prev = calibration_trigger_pin;
      // data phase of a write
      if (s_r.wr_pend) begin
         unique case (s_r.addr)
            adcss_pkg::ADDR_RESET_CTRL: soft_rst = w[0]; // [R4]
            adcss_pkg::ADDR_SYNTH_CTRL: begin
               s_nxt.synth_reset = w[adcss_pkg::SYNTH_RESET_BIT];
               s_nxt.trim_cal_en = w[adcss_pkg::TRIM_CAL_EN_BIT];
               s_nxt.bias = w[adcss_pkg::BIAS_LSB +: 8];
               s_nxt.trim = w[adcss_pkg::TRIM_LSB +: 8];
            end
            adcss_pkg::ADDR_SYNTH_DIV: s_nxt.div = w[23:0];
            adcss_pkg::ADDR_LINK_CTRL:
               s_nxt.link_en = w[adcss_pkg::LINK_EN_BIT]; // [R7]
            adcss_pkg::ADDR_LINK_CFG: if (!s_r.link_en) begin // [R7]
               s_nxt.mode = w[adcss_pkg::MODE_LSB +: 8];
               s_nxt.km1 = w[adcss_pkg::KM1_LSB +: 8];
               s_nxt.sync_sel = w[adcss_pkg::SYNC_SEL_BIT];
            end
            adcss_pkg::ADDR_CAL_CTRL: begin
               wr_cal = 1'b1;
               s_nxt.cal_en = w[adcss_pkg::CAL_EN_BIT]; // [R8]
               s_nxt.over_range_enable = w[adcss_pkg::OVER_RANGE_ENABLE_BIT];
               s_nxt.soft_trig = w[adcss_pkg::SOFT_TRIG_BIT];
               s_nxt.pin_trig_en = w[adcss_pkg::PIN_TRIG_EN_BIT];
               s_nxt.stat_sel = w[adcss_pkg::STAT_SEL_BIT];
            end
            adcss_pkg::ADDR_CAL_CFG: if (!s_r.cal_en) begin // [R8]
               s_nxt.cal_cfg = w[7:0];
            end
            adcss_pkg::ADDR_TRIG_OUT: s_nxt.trig_ctrl = w[7:0];
            default: ;
         endcase
      end
      // synth sequencing; trim cal starts on reset release
      unique case (s_r.syn)
         ST_INIT: if (tmr_done) begin
            s_nxt.init_done = 1'b1; // [R4]
            s_nxt.syn = ST_IDLE;
         end
         ST_IDLE: if (synth_enable_strap && !s_nxt.synth_reset &&
                      s_r.synth_reset) begin // [R6]
            tmr_load = 1'b1;
            tmr_count = s_nxt.trim_cal_en ? 12'(adcss_pkg::TRIM_CAL_CYCLES)
                                          : 12'(1);
            s_nxt.syn = ST_TRIM;
         end
         ST_TRIM: if (tmr_done) begin
            s_nxt.trim_done = 1'b1; // [R6]
            tmr_load = 1'b1;
            tmr_count = 12'(adcss_pkg::LOCK_CYCLES);
            s_nxt.syn = ST_LOCKING;
         end
         ST_LOCKING: if (tmr_done) begin
            s_nxt.locked = 1'b1; // [R6]
            s_nxt.syn = ST_IDLE;
         end
         default: s_nxt.syn = ST_IDLE;
      endcase
      if (s_nxt.synth_reset && s_r.syn != ST_INIT) begin
         s_nxt.trim_done = 1'b0;
         s_nxt.locked = 1'b0;
         s_nxt.syn = ST_IDLE;
         tmr_hold = 1'b1;
      end
      // foreground calibration trigger: soft bit or pin rising edge
      trig = (wr_cal && !s_r.soft_trig && s_nxt.soft_trig) ||
             (s_r.pin_trig_en && !s_r.pin_prev &&
              calibration_trigger_pin); // [R14]
      if (!s_r.cal_en) begin
         s_nxt.cal_busy = 1'b0; // [R8]
      end else if (trig && !s_r.cal_busy) begin
         s_nxt.cal_busy = 1'b1;
         s_nxt.foreground_done_bit = 1'b0;
         cal_load = 1'b1;
      end else if (cal_done && s_r.cal_busy) begin
         s_nxt.cal_busy = 1'b0;
         s_nxt.foreground_done_bit = 1'b1; // [R15]
      end
      // outputs
      s_nxt.stat_pin = s_nxt.foreground_done_bit; // [R15]
      s_nxt.link_run = s_r.link_en; // [R7]
      s_nxt.sync_req = s_r.link_en && is_8b10b && !sync_in; // [R16]
      s_nxt.valid = s_r.link_en && rx_locked &&
                    ((s_r.stat_pin && !s_r.stat_sel) || s_r.foreground_done_bit); // [R17]
      if (soft_rst) begin
         s_nxt = '0;
         s_nxt.syn = ST_INIT;
         s_nxt.bias = adcss_pkg::BIAS_RESET;
         s_nxt.mode = adcss_pkg::MODE_RESET;
         s_nxt.km1 = adcss_pkg::KM1_RESET;
         s_nxt.cal_cfg = adcss_pkg::CAL_CFG_RESET;
         s_nxt.synth_reset = 1'b1;
         s_nxt.link_en = 1'b1;
         s_nxt.cal_en = 1'b1;
         s_nxt.soft_trig = 1'b1;
         s_nxt.pin_prev = calibration_trigger_pin;
         tmr_load = 1'b1;
         tmr_hold = 1'b0; // reload must beat the synth hold
         tmr_count = 12'(adcss_pkg::INIT_CYCLES);
      end
      // bus side survives a soft reset; a read takes one wait state
      // so its data come from a register, not from the address phase
      s_nxt.rdata = s_r.rd_pend ? rd_mux : s_r.rdata;
      s_nxt.ready = 1'b1;
      if (hsel && hready && htrans[1]) begin
         s_nxt.addr = haddr[7:0];
         s_nxt.wr_pend = hwrite;
         s_nxt.rd_pend = !hwrite;
         s_nxt.ready = hwrite;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
         s_r.syn <= ST_IDLE;
         s_r.init_done <= 1'b1;
         s_r.synth_reset <= 1'b1;
         s_r.km1 <= adcss_pkg::KM1_RESET;
         s_r.link_en <= 1'b1;
         s_r.cal_en <= 1'b1;
         s_r.soft_trig <= 1'b1;
         s_r.ready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hrdata = s_r.rdata;
   assign hreadyout = s_r.ready;
   assign hresp = 1'b0;
   assign calibration_status_pin = s_r.stat_pin;
   assign link_running = s_r.link_run;
   assign link_sync_request = s_r.sync_req;
   assign data_valid = s_r.valid;
endmodule

/* File: src/adcss_pkg.sv */
package adcss_pkg;
   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] ADDR_RESET_CTRL = 8'h00;
   localparam logic [7:0] ADDR_INIT_STAT = 8'h04;
   localparam logic [7:0] ADDR_SYNTH_CTRL = 8'h08;
   localparam logic [7:0] ADDR_SYNTH_DIV = 8'h0C;
   localparam logic [7:0] ADDR_SYNTH_STAT = 8'h10;
   localparam logic [7:0] ADDR_LINK_CTRL = 8'h14;
   localparam logic [7:0] ADDR_LINK_CFG = 8'h18;
   localparam logic [7:0] ADDR_CAL_CTRL = 8'h1C;
   localparam logic [7:0] ADDR_CAL_CFG = 8'h20;
   localparam logic [7:0] ADDR_CAL_STAT = 8'h24;
   localparam logic [7:0] ADDR_TRIG_OUT = 8'h28;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int SYNTH_RESET_BIT = 0;
   localparam int TRIM_CAL_EN_BIT = 1;
   localparam int BIAS_LSB = 8;
   localparam int TRIM_LSB = 16;
   localparam int DIV_P_LSB = 0;
   localparam int DIV_V_LSB = 8;
   localparam int DIV_N_LSB = 16;
   localparam int LINK_EN_BIT = 0;
   localparam int MODE_LSB = 0;
   localparam int KM1_LSB = 8;
   localparam int SYNC_SEL_BIT = 16;
   localparam int CAL_EN_BIT = 0;
   localparam int OVER_RANGE_ENABLE_BIT = 1;
   localparam int SOFT_TRIG_BIT = 2;
   localparam int PIN_TRIG_EN_BIT = 3;
   localparam int STAT_SEL_BIT = 4;
   // ************************************************************
   // reset values and timing
   // ************************************************************
   localparam logic [7:0] BIAS_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] KM1_RESET = 8'h1F;
   localparam logic [7:0] CAL_CFG_RESET = 8'h00;
   localparam int CLK_MHZ = 200;
   localparam int INIT_TIME_NS = 1000;
   localparam int INIT_CYCLES = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int TRIM_CAL_CYCLES = 64;
   localparam int LOCK_CYCLES = 32;
   localparam int FG_CAL_CYCLES = 128;
   localparam logic [7:0] MODES_64B66B_FIRST = 8'h08;
endpackage

/* File: src/adcss_timer.sv */
`timescale 1ns/10ps
// one-shot down counter: load then count, done when it reaches zero
module adcss_timer #(
   parameter int WIDTH = 12
) (
   input wire logic sys_clk, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic load, // start a new interval
   input wire logic hold, // keep counter at zero, done low
   input wire logic [WIDTH-1:0] count, // interval length
   output logic done // interval elapsed
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic run;
      logic done;
   } adcss_tmr_t;
   adcss_tmr_t s_r;
   adcss_tmr_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (hold) begin
         s_nxt = '0;
      end else if (load) begin
         s_nxt.cnt = count;
         s_nxt.run = 1'b1;
         s_nxt.done = 1'b0;
      end else if (s_r.run) begin
         if (s_r.cnt <= WIDTH'(1)) begin
            s_nxt.run = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.cnt = '0;
         end else begin
            s_nxt.cnt = s_r.cnt - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign done = s_r.done;
endmodule

/* File: verification/adcss_core_props.sv */
`timescale 1ns/10ps
// ************************************************************
// port checker for the startup sequencer core
// ************************************************************
module adcss_core_props (
   input wire logic sys_clk, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic hsel, // ahb select
   input wire logic hready, // ahb bus ready
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic [31:0] hrdata, // ahb read data
   input wire logic hreadyout, // slave ready
   input wire logic hresp, // slave response
   input wire logic single_ended_sync_input, // sync pin, low active
   input wire logic timestamp_diff_input, // timestamp sync, low active
   input wire logic rx_locked, // receiver init finished
   input wire logic calibration_status_pin, // calibration finished
   input wire logic link_running, // link machine running
   input wire logic link_sync_request, // link in code-group sync
   input wire logic data_valid // converter data usable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence acc_s;
      hsel && hready && htrans[1];
   endsequence
   sequence link_wr_s;
      acc_s ##0 (hwrite && haddr[7:0] == adcss_pkg::ADDR_LINK_CTRL);
   endsequence
   sequence stat_low_s;
      !calibration_status_pin [*8];
   endsequence
   AST_BUS_OKAY: assert property (!hresp and
      (!hreadyout |-> $past(hsel && htrans[1] && !hwrite)) and
      (!hreadyout |=> hreadyout))
      else $error("bus answer not okay or wait state misplaced");
   AST_RESET_OUTS: assert property (
      !$past(reset_n) |-> !(data_valid || calibration_status_pin ||
      link_running || link_sync_request))
      else $error("outputs not idle after reset");
   AST_HRDATA_HOLD: assert property (
      !(hsel && hready && htrans[1] && !hwrite) |-> ##2 $stable(hrdata))
      else $error("read data moved without a read");
   AST_LINK_FOLLOW: assert property (
      link_wr_s |=> ##2 (link_running == $past(hwdata[0], 2)))
      else $error("link running does not follow link enable");
   AST_SYNC_NEEDS_RUN: assert property (
      link_sync_request |-> link_running)
      else $error("sync request while link halted");
   AST_SYNC_CAUSE: assert property (
      $rose(link_sync_request) |->
      $past(!single_ended_sync_input || !timestamp_diff_input))
      else $error("sync request without a low sync input");
   AST_DV_LOCK: assert property (
      $rose(data_valid) |-> $past(rx_locked))
      else $error("data valid before receiver lock");
   AST_DV_CAL: assert property (
      $rose(data_valid) |-> ##[0:1] calibration_status_pin)
      else $error("data valid before calibration end");
   AST_STAT_LOW: assert property (
      $fell(calibration_status_pin) |-> stat_low_s)
      else $error("calibration status back high too soon");
endmodule

bind adcss_core adcss_core_props u_props (.sys_clk, .reset_n, .haddr,
   .htrans, .hwrite, .hsel, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
   .single_ended_sync_input, .timestamp_diff_input, .rx_locked,
   .calibration_status_pin, .link_running, .link_sync_request, .data_valid);

/* File: verification/adcss_rx_model.sv */
`timescale 1ns/10ps
// ************************************************************
// receiver on the far end of the link
// ************************************************************
module adcss_rx_model (
   input wire logic sys_clk, // core clock, a whole multiple of
   input wire logic reset_n, // async reset, active low
   input wire logic link_running, // device link up
   input wire logic [7:0] lock_dly, // cycles to lock, sets the pace
   output logic sync_req_n, // sync request, low active
   output logic rx_locked // receiver init complete
);
   logic [7:0] cnt_r;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         cnt_r <= 8'h00;
      else if (!link_running)
         cnt_r <= 8'h00;
      else if (cnt_r != lock_dly)
         cnt_r <= cnt_r + 8'h01;
   end
   // a halted link drops lock, so realignment starts over
   assign rx_locked = link_running && (cnt_r == lock_dly);
   assign sync_req_n = rx_locked;
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
// ************************************************************
// bench for the startup sequencer core
// ************************************************************
module tb_top;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0, hreadyout, hresp, se_sync, rx_locked;
   logic ts = 1'b1, trig = 1'b1, cal_stat, link_run, sync_req, dv;
   logic synth_en = 1'b1, ref_se = 1'b1;
   logic [7:0] lock_dly = 8'h28;
   logic rd_ph = 1'b0;
   logic [31:0] exp_q[$];
   int fail_count = 0, checks = 0, seed = 99732;
   always #2.5 sys_clk = ~sys_clk;
   adcss_core dut (.sys_clk(sys_clk), .reset_n(reset_n), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hsel(1'b1),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .synth_enable_strap(synth_en),
      .ref_input_select_strap(ref_se), .single_ended_sync_input(se_sync),
      .timestamp_diff_input(ts), .calibration_trigger_pin(trig),
      .rx_locked(rx_locked), .calibration_status_pin(cal_stat),
      .link_running(link_run), .link_sync_request(sync_req),
      .data_valid(dv));
   adcss_rx_model rx (.sys_clk(sys_clk), .reset_n(reset_n),
      .link_running(link_run), .lock_dly(lock_dly), .sync_req_n(se_sync),
      .rx_locked(rx_locked));
   task automatic results;
      if (exp_q.size() != 0)
         fail_count++;
      if (fail_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic got, input logic exp);
      chk_rd({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wt;
      int n;
      n = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            fail_count++;
            results();
         end
         @(posedge sys_clk);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wt();
      htrans <= 2'h0;
      hwdata <= d;
      wt();
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0, q);
   endtask
   // every status poll is bounded, a hang is a failure
   task automatic poll(input logic [7:0] a, input logic [31:0] m);
      logic [31:0] q;
      int n;
      q = 32'h0;
      n = 0;
      while ((q & m) !== m) begin
         if (n == 300) begin
            fail_count++;
            results();
         end
         n++;
         xfer(1'b0, a, 32'h0, q);
      end
   endtask
   always @(posedge sys_clk) begin
      if (rd_ph && hreadyout === 1'b1 && exp_q.size() > 0)
         chk_rd(hrdata, exp_q.pop_front());
      if (hreadyout === 1'b1)
         rd_ph <= htrans[1] && !hwrite;
   end
   initial begin
      logic [31:0] v, cfg;
      int i;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(adcss_pkg::ADDR_INIT_STAT, 32'h1);
      rd(adcss_pkg::ADDR_LINK_CTRL, 32'h1);
      rd(adcss_pkg::ADDR_CAL_CTRL, 32'h5);
      wr(adcss_pkg::ADDR_LINK_CFG, 32'h00010208);
      rd(adcss_pkg::ADDR_LINK_CFG, 32'h00001F00);
      wr(adcss_pkg::ADDR_CAL_CFG, 32'h5);
      rd(adcss_pkg::ADDR_CAL_CFG, 32'h0);
      wr(8'h3C, 32'hFFFFFFFF);
      rd(8'h3C, 32'h0);
      wr(adcss_pkg::ADDR_RESET_CTRL, 32'h1);
      rd(adcss_pkg::ADDR_INIT_STAT, 32'h0);
      poll(adcss_pkg::ADDR_INIT_STAT, 32'h1);
      wr(adcss_pkg::ADDR_SYNTH_CTRL, 32'h00004A03);
      v = $random(seed) & 32'h00FFFFFF;
      wr(adcss_pkg::ADDR_SYNTH_DIV, v);
      rd(adcss_pkg::ADDR_SYNTH_DIV, v);
      wr(adcss_pkg::ADDR_SYNTH_CTRL, 32'h00004A02);
      rd(adcss_pkg::ADDR_SYNTH_STAT, 32'h0);
      poll(adcss_pkg::ADDR_SYNTH_STAT, 32'h3);
      wr(adcss_pkg::ADDR_CAL_CTRL, 32'h4);
      wr(adcss_pkg::ADDR_CAL_CFG, 32'h5);
      rd(adcss_pkg::ADDR_CAL_CFG, 32'h5);
      // 8b/10b and 64b/66b, both sync sources, both timestamp levels
      for (i = 0; i < 4; i++) begin
         wr(adcss_pkg::ADDR_LINK_CTRL, 32'h0);
         v = $random(seed);
         ts <= i[1] ? i[0] : v[0];
         cfg = {15'h0, i[1], 8'h0F, (i == 1) ? 8'h08 : 8'h00};
         wr(adcss_pkg::ADDR_LINK_CFG, cfg);
         rd(adcss_pkg::ADDR_LINK_CFG, cfg);
         wr(adcss_pkg::ADDR_LINK_CTRL, 32'h1);
         repeat (6) @(posedge sys_clk);
         #1;
         chk_pin(sync_req, !i[0]);
      end
      wr(adcss_pkg::ADDR_LINK_CTRL, 32'h0);
      wr(adcss_pkg::ADDR_LINK_CFG, 32'h00001F00);
      wr(adcss_pkg::ADDR_CAL_CTRL, 32'h3);
      wr(adcss_pkg::ADDR_LINK_CTRL, 32'h1);
      wr(adcss_pkg::ADDR_CAL_CTRL, 32'h7);
      rd(adcss_pkg::ADDR_CAL_STAT, 32'h2);
      chk_pin(dv, 1'b0);
      poll(adcss_pkg::ADDR_CAL_STAT, 32'h1);
      repeat (2) @(posedge sys_clk);
      #1;
      chk_pin(cal_stat, 1'b1);
      chk_pin(dv, 1'b1);
      wr(adcss_pkg::ADDR_CAL_CTRL, 32'h3);
      wr(adcss_pkg::ADDR_CAL_CTRL, 32'h7);
      wr(adcss_pkg::ADDR_CAL_CTRL, 32'h6);
      rd(adcss_pkg::ADDR_CAL_STAT, 32'h0);
      chk_pin(dv, 1'b0);
      wr(adcss_pkg::ADDR_CAL_CTRL, 32'hD);
      @(posedge sys_clk);
      trig <= 1'b0;
      repeat (2) @(posedge sys_clk);
      trig <= 1'b1;
      poll(adcss_pkg::ADDR_CAL_STAT, 32'h1);
      repeat (2) @(posedge sys_clk);
      #1;
      chk_pin(cal_stat, 1'b1);
      results();
   end
endmodule
